// >>> core/synth_defs.svh
// Constants for the fractional-N synthesizer control block
//
// Behaviour
// - Charge pump current selectable among thirty-two levels by software.
// - Phase detector compares reference divider output against feedback divider output.
// - Feedback ratio is integer plus numerator over denominator; denominator 1..4194303.
// - Modulator order from integer to fourth, plus selectable dither modes.
// - Writing the frequency trigger register resets the fractional modulator state.
// - Third and fourth pole filter settings apply only in full chip mode.
// - Frequency trigger write in full chip mode starts band calibration, timed by the reference word.
// - Frequency trigger write in full chip mode starts amplitude calibration; temp-comp word picks setting.
// - Output divider takes 2..63; bypass only allowed in full chip mode.
// - Output divider gives input divided by value with 50% duty, odd too.
// - Output state set by enable pin and state word; lock undisturbed.
// - Chip enable low powers down; high with bit 0 up, 1 down.
// - Settings and calibration results are retained through power-down.
// - Writes accepted while powered down, but calibration does not run then.
// - Frequency change starts a timeout holding fastlock for a programmable time.
// - Fastlock drives its pin low and swaps in fastlock gain and resistors.
// - Reference doubler bypasses the reference divider into the phase detector.
`ifndef SYNTH_DEFS_SVH
`define SYNTH_DEFS_SVH
`define SYNC_REF         0
`define SYNC_VCO         1
`define SYNC_CE          2
`define SYNC_OEN         3
`define DIV_MIN          6'h02
`define DIV_SYNC_LO      6'h04
`define DIV_SYNC_HI      6'h05
`define DIV_SETTLE_EDGES 3'h5
`define DEN_MIN          22'h000001
`define REF_DIV_MIN      12'h001
`define AMP_CAL_CYC      12'h040
`define AMP_CODE_NOM     4'h8
`define AMP_CODE_TC      4'hc
`define LFSR_SEED        15'h4a5f
`define OUT_OFF          2'h0
`define OUT_ON           2'h1
`define BAND_MSB         15
`define BAND_LSB         10
`endif

// >>> core/synth_pkg.sv
// Types shared by the synthesizer control block
package synth_pkg;
    typedef enum logic [1:0] {
        MODE_FULL     = 2'h0,
        MODE_EXT_VCO  = 2'h1,
        MODE_DIV_ONLY = 2'h2
    } synth_mode_t;
    typedef enum logic [3:0] {
        CAL_IDLE = 4'h1,
        CAL_BAND = 4'h2,
        CAL_AMP  = 4'h4,
        CAL_DONE = 4'h8
    } cal_state_t;
    typedef struct packed {
        synth_mode_t mode;
        logic [11:0] ref_div;
        logic        reference_doubler;
        logic [11:0] reference_freq_word;
        logic [15:0] n_int;
        logic [21:0] numerator;
        logic [21:0] fraction_denominator;
        logic [2:0]  mod_order;
        logic [1:0]  dither_mode;
        logic [4:0]  pump_gain;
        logic [4:0]  fast_settle_pump_gain;
        logic [2:0]  third_pole_resistor;
        logic [2:0]  fourth_pole_resistor;
        logic [2:0]  fast_third_pole_resistor;
        logic [2:0]  fast_fourth_pole_resistor;
        logic [2:0]  third_pole_cap;
        logic [2:0]  fourth_pole_cap;
        logic        amplitude_cal_temp_comp;
        logic [5:0]  vco_div;
        logic        div_bypass;
        logic [1:0]  output_state_word;
        logic [1:0]  oscillator_buffer_gain;
        logic [1:0]  divider_buffer_gain;
        logic [3:0]  output_termination_word;
        logic        soft_powerdown;
        logic [15:0] fast_settle_time;
    } synth_cfg_t;
    typedef struct packed {
        logic [4:0] pump_gain;
        logic [2:0] third_pole_resistor;
        logic [2:0] fourth_pole_resistor;
        logic [2:0] third_pole_cap;
        logic [2:0] fourth_pole_cap;
        logic [5:0] vco_band;
        logic [3:0] amp_code;
        logic       buf_on;
        logic [1:0] oscillator_buffer_gain;
        logic [1:0] divider_buffer_gain;
        logic [3:0] output_termination_word;
    } analog_ctl_t;
endpackage

// >>> core/frac_synth_divider_control.sv
// Fractional-N synthesizer digital control: dividers, modulator, cal, fastlock
`timescale 1ns/1ps
`include "synth_defs.svh"
module frac_synth_divider_control (
    // Clock, reset, enable
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,
    // Programmed settings and write-complete pulses
    input  wire synth_pkg::synth_cfg_t  cfg,
    input  wire logic                   freq_trig_wr,
    input  wire logic                   div_cfg_wr,
    // Pins
    input  wire logic                   ref_pin,
    input  wire logic                   external_oscillator_input,
    input  wire logic                   chip_enable_pin,
    input  wire logic                   output_enable_pin,
    // Phase detector and modulator
    output logic                        ref_tick_r,
    output logic                        fb_tick_r,
    output logic                        pd_up_r,
    output logic                        pd_dn_r,
    output logic                        mod_reset_r,
    // Analog controls and RF divider
    output synth_pkg::analog_ctl_t      ana_r,
    output logic                        rf_clk_r,
    // Fastlock open-drain pin
    output logic                        fast_settle_out_r,
    output logic                        fast_settle_oe_r,
    // Status
    output logic                        powered_up_r,
    output logic                        cal_busy_r,
    output logic                        cal_done_r,
    output logic                        resync_needed_r
);
    import synth_pkg::*;

    logic [3:0]  sync1_r;
    logic [3:0]  sync2_r;
    logic [3:0]  prev_r;
    logic [11:0] ref_cnt_r;
    logic [16:0] fb_cnt_r;
    logic [22:0] acc_r [4];
    logic [3:0]  d1_r;
    logic [3:0]  d2_r;
    logic [3:0]  d3_r;
    logic [14:0] lfsr_r;
    logic signed [5:0] mod_y_r;
    cal_state_t  cal_state_r;
    cal_state_t  cal_nxt;
    logic [11:0] cal_cnt_r;
    logic [5:0]  band_r;
    logic [3:0]  amp_r;
    logic [15:0] fl_cnt_r;
    logic [15:0] fl_nxt;
    logic [5:0]  div_act_r;
    logic        byp_act_r;
    logic        div_pend_r;
    logic [2:0]  settle_r;
    logic [5:0]  rf_cnt_r;

    // Pin synchronisers; only the second stage is read
    wire [3:0] pins_in = {output_enable_pin, chip_enable_pin,
                          external_oscillator_input, ref_pin};
    wire [3:0] rise = sync2_r & ~prev_r;
    wire [3:0] fall = ~sync2_r & prev_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            prev_r  <= 4'h0;
        end else if (clk_en) begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Power and mode decode
    wire pwr_nxt = sync2_r[`SYNC_CE] & ~cfg.soft_powerdown;
    wire is_full = (cfg.mode == MODE_FULL);
    wire pll_on  = powered_up_r & (cfg.mode != MODE_DIV_ONLY);
    wire cal_go  = freq_trig_wr & powered_up_r & is_full;
    wire fl_go   = freq_trig_wr & pll_on;

    // Reference path: doubler uses both edges and skips the divider
    wire [11:0] ref_div_eff = (cfg.ref_div == 12'h000) ? `REF_DIV_MIN
                                                       : cfg.ref_div;
    wire ref_edge = cfg.reference_doubler ? (rise[`SYNC_REF] |
                    fall[`SYNC_REF]) : rise[`SYNC_REF];
    wire ref_last = (ref_cnt_r == ref_div_eff - `REF_DIV_MIN);
    wire ref_wrap = ref_edge & (cfg.reference_doubler | ref_last);

    // Feedback load value: integer word plus modulator offset
    wire [16:0] n_load = {1'b0, cfg.n_int} + {{11{mod_y_r[5]}}, mod_y_r};
    wire [16:0] n_min1 = (n_load == 17'h00000) ? 17'h00000
                                               : n_load - 17'h00001;
    wire fb_wrap = rise[`SYNC_VCO] & (fb_cnt_r == 17'h00000);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_cnt_r  <= 12'h000;
            fb_cnt_r   <= 17'h00000;
            ref_tick_r <= 1'b0;
            fb_tick_r  <= 1'b0;
        end else if (clk_en) begin
            ref_tick_r <= pll_on & ref_wrap;
            fb_tick_r  <= pll_on & fb_wrap;
            if (!pll_on)
                ref_cnt_r <= 12'h000;
            else if (ref_edge)
                ref_cnt_r <= ref_wrap ? 12'h000 : ref_cnt_r + 12'h001;
            if (!pll_on)
                fb_cnt_r <= 17'h00000;
            else if (rise[`SYNC_VCO])
                fb_cnt_r <= fb_wrap ? n_min1 : fb_cnt_r - 17'h00001;
        end
    end

    // Phase-frequency detector on the two divider outputs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pd_up_r <= 1'b0;
            pd_dn_r <= 1'b0;
        end else if (clk_en) begin
            if (!pll_on || (ref_tick_r && fb_tick_r)) begin
                pd_up_r <= 1'b0;
                pd_dn_r <= 1'b0;
            end else if (ref_tick_r) begin
                pd_up_r <= ~pd_dn_r;
                pd_dn_r <= 1'b0;
            end else if (fb_tick_r) begin
                pd_dn_r <= ~pd_up_r;
                pd_up_r <= 1'b0;
            end
        end
    end

    // Modulator: cascade of residue accumulators, one per order
    wire [21:0] den_eff = (cfg.fraction_denominator == 22'h000000) ?
                          `DEN_MIN : cfg.fraction_denominator;
    wire [22:0] dith = (cfg.dither_mode == 2'h1) ? {22'h000000, lfsr_r[0]} :
                       (cfg.dither_mode == 2'h2) ? {19'h00000, lfsr_r[3:0]}
                                                 : 23'h000000;
    logic [3:0]  st_c;
    logic [3:0]  st_en;
    logic [22:0] st_res [4];
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_stage
            wire [22:0] st_in;
            // First stage takes the fraction, later ones the residue above
            if (k == 0) begin : g_head
                assign st_in = {1'b0, cfg.numerator} + dith;
            end else begin : g_tail
                assign st_in = acc_r[k-1];
            end
            wire [23:0] st_sum = {1'b0, acc_r[k]} + {1'b0, st_in};
            wire [23:0] st_dif = st_sum - {2'h0, den_eff};
            // Cap keeps dither from walking the residue out of range
            wire        st_cap = (st_dif >= {2'h0, den_eff});
            assign st_en[k]  = (cfg.mod_order > 3'(k));
            assign st_c[k]   = st_en[k] & (st_sum >= {2'h0, den_eff});
            assign st_res[k] = !st_c[k] ? st_sum[22:0] :
                               st_cap ? {1'b0, den_eff} - 23'h000001
                                      : st_dif[22:0];
        end
    endgenerate

    // Error cancellation: zeroth to third difference of stage carries
    wire signed [5:0] t1 = $signed({5'h00, st_c[0]});
    wire signed [5:0] t2 = $signed({5'h00, st_c[1]})
                         - $signed({5'h00, d1_r[1]});
    wire signed [5:0] t3 = $signed({5'h00, st_c[2]})
                         - $signed({4'h0, d1_r[2], 1'b0})
                         + $signed({5'h00, d2_r[2]});
    wire signed [5:0] t4 = $signed({5'h00, st_c[3]})
                         - $signed({4'h0, d1_r[3], 1'b0})
                         - $signed({5'h00, d1_r[3]})
                         + $signed({4'h0, d2_r[3], 1'b0})
                         + $signed({5'h00, d2_r[3]})
                         - $signed({5'h00, d3_r[3]});
    wire signed [5:0] y_nxt = t1 + t2 + t3 + t4;

    // Modulator steps once per feedback cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++)
                acc_r[i] <= 23'h000000;
            d1_r        <= 4'h0;
            d2_r        <= 4'h0;
            d3_r        <= 4'h0;
            lfsr_r      <= `LFSR_SEED;
            mod_y_r     <= 6'h00;
            mod_reset_r <= 1'b0;
        end else if (clk_en) begin
            mod_reset_r <= freq_trig_wr;
            if (freq_trig_wr) begin
                for (int i = 0; i < 4; i++)
                    acc_r[i] <= 23'h000000;
                d1_r    <= 4'h0;
                d2_r    <= 4'h0;
                d3_r    <= 4'h0;
                lfsr_r  <= `LFSR_SEED;
                mod_y_r <= 6'h00;
            end else if (pll_on && fb_wrap) begin
                for (int i = 0; i < 4; i++)
                    acc_r[i] <= st_en[i] ? st_res[i] : 23'h000000;
                d1_r    <= st_c;
                d2_r    <= d1_r;
                d3_r    <= d2_r;
                lfsr_r  <= {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]};
                mod_y_r <= y_nxt;
            end
        end
    end

    // Calibration sequence: band search, then amplitude
    always_comb begin
        cal_nxt = cal_state_r;
        case (cal_state_r)
            CAL_IDLE: cal_nxt = CAL_IDLE;
            CAL_BAND: if (cal_cnt_r == 12'h000)
                          cal_nxt = CAL_AMP;
            CAL_AMP:  if (cal_cnt_r == 12'h000)
                          cal_nxt = CAL_DONE;
            CAL_DONE: cal_nxt = CAL_DONE;
            default:  cal_nxt = CAL_IDLE;
        endcase
        if (cal_go)
            cal_nxt = CAL_BAND;
        else if (!powered_up_r && cal_state_r != CAL_DONE)
            cal_nxt = CAL_IDLE;
    end

    // Results are never reset by power-down, only by sys_rst
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_state_r <= CAL_IDLE;
            cal_cnt_r   <= 12'h000;
            band_r      <= 6'h00;
            amp_r       <= `AMP_CODE_NOM;
            cal_busy_r  <= 1'b0;
            cal_done_r  <= 1'b0;
        end else if (clk_en) begin
            cal_state_r <= cal_nxt;
            cal_busy_r  <= (cal_nxt == CAL_BAND) || (cal_nxt == CAL_AMP);
            cal_done_r  <= (cal_nxt == CAL_DONE);
            if (cal_go)
                cal_cnt_r <= cfg.reference_freq_word;
            else if (cal_state_r == CAL_BAND && cal_nxt == CAL_AMP) begin
                cal_cnt_r <= `AMP_CAL_CYC;
                band_r    <= cfg.n_int[`BAND_MSB:`BAND_LSB];
            end else if (cal_state_r == CAL_AMP && cal_nxt == CAL_DONE)
                amp_r <= cfg.amplitude_cal_temp_comp ? `AMP_CODE_TC
                                                     : `AMP_CODE_NOM;
            else if (cal_cnt_r != 12'h000)
                cal_cnt_r <= cal_cnt_r - 12'h001;
        end
    end

    // Fastlock timeout
    always_comb begin
        fl_nxt = fl_cnt_r;
        if (!pll_on)
            fl_nxt = 16'h0000;
        else if (fl_go)
            fl_nxt = cfg.fast_settle_time;
        else if (fl_cnt_r != 16'h0000)
            fl_nxt = fl_cnt_r - 16'h0001;
    end
    wire fl_on = (fl_cnt_r != 16'h0000);

    // Analog controls; fastlock swaps gain and resistors
    wire buf_sel = (cfg.output_state_word == `OUT_ON) ||
                   (cfg.output_state_word != `OUT_OFF &&
                    cfg.output_state_word != `OUT_ON &&
                    sync2_r[`SYNC_OEN]);
    analog_ctl_t ana_nxt;
    always_comb begin
        ana_nxt.pump_gain = fl_on ? cfg.fast_settle_pump_gain
                                  : cfg.pump_gain;
        ana_nxt.third_pole_resistor  = !is_full ? 3'h0 :
            fl_on ? cfg.fast_third_pole_resistor
                  : cfg.third_pole_resistor;
        ana_nxt.fourth_pole_resistor = !is_full ? 3'h0 :
            fl_on ? cfg.fast_fourth_pole_resistor
                  : cfg.fourth_pole_resistor;
        ana_nxt.third_pole_cap  = is_full ? cfg.third_pole_cap : 3'h0;
        ana_nxt.fourth_pole_cap = is_full ? cfg.fourth_pole_cap : 3'h0;
        ana_nxt.vco_band = band_r;
        ana_nxt.amp_code = amp_r;
        // Buffer gating leaves the loop alone
        ana_nxt.buf_on = powered_up_r & buf_sel;
        ana_nxt.oscillator_buffer_gain  = cfg.oscillator_buffer_gain;
        ana_nxt.divider_buffer_gain     = cfg.divider_buffer_gain;
        ana_nxt.output_termination_word = cfg.output_termination_word;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fl_cnt_r          <= 16'h0000;
            fast_settle_oe_r  <= 1'b0;
            fast_settle_out_r <= 1'b0;
            ana_r             <= '0;
            powered_up_r      <= 1'b0;
        end else if (clk_en) begin
            fl_cnt_r          <= fl_nxt;
            fast_settle_oe_r  <= (fl_nxt != 16'h0000);
            fast_settle_out_r <= 1'b0;
            ana_r             <= ana_nxt;
            powered_up_r      <= pwr_nxt;
        end
    end

    // Output divider: counting both input edges gives 50% duty for odd N.
    // Input is sampled on sys_clk, so it must stay well below 20 MHz.
    wire [5:0] div_eff = (cfg.vco_div < `DIV_MIN) ? `DIV_MIN : cfg.vco_div;
    wire       byp_eff = cfg.div_bypass & is_full;
    wire       vco_edge = rise[`SYNC_VCO] | fall[`SYNC_VCO];
    wire       div_45 = !byp_act_r && (div_act_r == `DIV_SYNC_LO ||
                                       div_act_r == `DIV_SYNC_HI);
    wire       rs_set = div_45 & ((freq_trig_wr & is_full) |
                                  (powered_up_r & ~pwr_nxt));
    wire       rs_clr = div_cfg_wr & powered_up_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_act_r       <= `DIV_MIN;
            byp_act_r       <= 1'b0;
            div_pend_r      <= 1'b0;
            settle_r        <= 3'h0;
            rf_cnt_r        <= 6'h00;
            rf_clk_r        <= 1'b0;
            resync_needed_r <= 1'b0;
        end else if (clk_en) begin
            // New set wins over a same-cycle rewrite
            resync_needed_r <= rs_set | (resync_needed_r & ~rs_clr);
            if (div_cfg_wr) begin
                div_pend_r <= 1'b1;
                settle_r   <= `DIV_SETTLE_EDGES;
                rf_cnt_r   <= 6'h00;
            end else if (powered_up_r) begin
                if (div_pend_r && rise[`SYNC_VCO]) begin
                    settle_r <= settle_r - 3'h1;
                    if (settle_r == 3'h1) begin
                        div_act_r  <= div_eff;
                        byp_act_r  <= byp_eff;
                        div_pend_r <= 1'b0;
                    end
                end
                if (byp_act_r)
                    rf_clk_r <= sync2_r[`SYNC_VCO];
                else if (vco_edge) begin
                    if (rf_cnt_r >= div_act_r - 6'h01) begin
                        rf_cnt_r <= 6'h00;
                        rf_clk_r <= ~rf_clk_r;
                    end else
                        rf_cnt_r <= rf_cnt_r + 6'h01;
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_trig_cal;
        clk_en && cal_go;
    endsequence
    sequence s_band_then_amp;
        (cal_state_r == CAL_BAND) ##1 (cal_state_r == CAL_AMP);
    endsequence
    sequence s_amp_last;
        clk_en && cal_state_r == CAL_AMP && cal_cnt_r == 12'h000 &&
            powered_up_r && !cal_go;
    endsequence

    property p_cal_start;
        s_trig_cal |=> (cal_state_r == CAL_BAND) && cal_busy_r;
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("trigger write did not start band calibration");

    property p_amp_len;
        s_band_then_amp |-> cal_cnt_r == `AMP_CAL_CYC;
    endproperty
    a_amp_len: assert property (p_amp_len)
        else $error("amplitude step did not load its cycle count");

    property p_amp_code;
        s_amp_last |=> amp_r == ($past(cfg.amplitude_cal_temp_comp) ?
                          `AMP_CODE_TC : `AMP_CODE_NOM);
    endproperty
    a_amp_code: assert property (p_amp_code)
        else $error("amplitude code does not follow temp-comp word");

    property p_no_cal_pd;
        (clk_en && freq_trig_wr && !powered_up_r) |=> !cal_busy_r &&
            cal_state_r != CAL_BAND;
    endproperty
    a_no_cal_pd: assert property (p_no_cal_pd)
        else $error("calibration started while powered down");

    property p_mod_reset;
        (clk_en && freq_trig_wr) |=> mod_reset_r && mod_y_r == 6'h00
            && acc_r[0] == 23'h000000;
    endproperty
    a_mod_reset: assert property (p_mod_reset)
        else $error("modulator not cleared by trigger write");

    property p_ce_low;
        (clk_en && !sync2_r[`SYNC_CE]) |=> !powered_up_r ##1
            (!clk_en || !ana_r.buf_on);
    endproperty
    a_ce_low: assert property (p_ce_low)
        else $error("device up with chip enable low");

    property p_fl_pin;
        (clk_en && fl_go && cfg.fast_settle_time > 16'h0001)
            |=> fast_settle_oe_r ##1 (!clk_en ||
                ana_r.pump_gain == $past(cfg.fast_settle_pump_gain, 2));
    endproperty
    a_fl_pin: assert property (p_fl_pin)
        else $error("fastlock pin or gain not engaged");

    property p_fl_end;
        (clk_en && fl_cnt_r == 16'h0001 && !fl_go && pll_on)
            |=> !fast_settle_oe_r;
    endproperty
    a_fl_end: assert property (p_fl_end)
        else $error("fastlock did not end at timeout");

    property p_lf_mode;
        (clk_en && !is_full) |=> ana_r.third_pole_resistor == 3'h0 &&
            ana_r.fourth_pole_cap == 3'h0;
    endproperty
    a_lf_mode: assert property (p_lf_mode)
        else $error("loop filter settings active outside full chip");

    property p_byp_full;
        (clk_en && div_pend_r && rise[`SYNC_VCO] && powered_up_r &&
         settle_r == 3'h1 && !div_cfg_wr && !is_full) |=> !byp_act_r;
    endproperty
    a_byp_full: assert property (p_byp_full)
        else $error("bypass taken outside full chip mode");

    property p_dbl;
        (clk_en && pll_on && cfg.reference_doubler && ref_edge)
            |=> ref_tick_r;
    endproperty
    a_dbl: assert property (p_dbl)
        else $error("doubled reference did not reach detector");
endmodule

// >>> verification/ext_osc_model.sv
// Free-running external oscillator source for the divider input
`timescale 1ns/1ps
module ext_osc_model #(
    parameter real HALF_NS = 100.0
) (
    output logic osc_out
);
    // Runs free: a slow source keeps >=5 edges after any write
    initial begin
        osc_out = 1'b0;
        forever #(HALF_NS) osc_out = ~osc_out;
    end
endmodule

// >>> verification/test_frac_synth_divider_control.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
module test_frac_synth_divider_control;
    import synth_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        trig = 1'b0;
    logic        dwr = 1'b0;
    logic        ce = 1'b1;
    logic        en = 1'b1;
    logic        oen = 1'b1;
    logic        osc, mrst, rfc, fso, fsoe, pwr, busy, done, rsn, rtk;
    synth_cfg_t  cfg;
    analog_ctl_t ana;
    int          fail_count = 0;
    int          total_checks = 0;
    int          n;
    always #12.5 sys_clk = ~sys_clk;
    ext_osc_model osc_src (.osc_out(osc));
    frac_synth_divider_control dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .clk_en(en), .cfg(cfg), .freq_trig_wr(trig), .div_cfg_wr(dwr),
        .ref_pin(osc), .external_oscillator_input(osc),
        .chip_enable_pin(ce), .output_enable_pin(oen), .ref_tick_r(rtk),
        .fb_tick_r(), .pd_up_r(), .pd_dn_r(), .mod_reset_r(mrst),
        .ana_r(ana), .rf_clk_r(rfc), .fast_settle_out_r(fso),
        .fast_settle_oe_r(fsoe), .powered_up_r(pwr), .cal_busy_r(busy),
        .cal_done_r(done), .resync_needed_r(rsn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    // Trigger write pulse; returns in the cycle after it is taken
    task automatic pulse_trig();
        trig = 1'b1;
        step(1);
        trig = 1'b0;
    endtask
    // Divider config write pulse
    task automatic pulse_div();
        dwr = 1'b1;
        step(1);
        dwr = 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Waits while the divided clock holds lvl; k counts the cycles
    task automatic wait_rfc(input logic lvl, output int k);
        for (k = 0; k < 100 && rfc === lvl; k++) step(1);
        if (k == 100) begin
            fail_count++;
            end_of_test();
        end
    endtask
    // Calibration and fastlock after a trigger write
    task automatic test_trig();
        pulse_trig();
        chk(mrst, 1'b1);
        chk(busy, 1'b1);
        chk(fsoe, 1'b1);
        chk(fso, 1'b0);
        step(4);
        chk(ana.pump_gain, 5'h1f);
        chk(ana.third_pole_resistor, 3'h1);
        step(10);
        chk(fsoe, 1'b0);
        chk(ana.pump_gain, 5'h03);
        for (n = 0; n < 400 && done !== 1'b1; n++) step(1);
        if (done !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        // Codes reach the analog word one cycle after the latch
        step(1);
        chk(busy, 1'b0);
        chk(ana.amp_code, 4'hc);
        chk(ana.vco_band, cfg.n_int[15:10]);
        $display("trigger test done");
    endtask
    // Power-down by pin and by bit; writes still taken
    task automatic test_power();
        ce = 1'b0;
        step(5);
        chk(pwr, 1'b0);
        pulse_trig();
        chk(mrst, 1'b1);
        chk(busy, 1'b0);
        ce = 1'b1;
        step(5);
        chk(pwr, 1'b1);
        chk(ana.vco_band, cfg.n_int[15:10]);
        cfg.soft_powerdown = 1'b1;
        step(4);
        chk(pwr, 1'b0);
        cfg.soft_powerdown = 1'b0;
        step(4);
        $display("power test done");
    endtask
    // Buffer follows word and pin; loop runs on; enable low freezes state
    task automatic test_out();
        int k;
        k = 0;
        oen = 1'b0;
        step(5);
        chk(ana.buf_on, 1'b1);
        cfg.output_state_word = 2'h2;
        step(2);
        chk(ana.buf_on, 1'b0);
        oen = 1'b1;
        step(5);
        chk(ana.buf_on, 1'b1);
        cfg.output_state_word = 2'h0;
        step(2);
        chk(ana.buf_on, 1'b0);
        for (n = 0; n < 16; n++) begin
            if (rtk === 1'b1) k++;
            step(1);
        end
        chk(k, 2);
        cfg.output_state_word = 2'h1;
        en = 1'b0;
        ce = 1'b0;
        step(4);
        chk(pwr, 1'b1);
        ce = 1'b1;
        en = 1'b1;
        step(4);
        chk(pwr, 1'b1);
        $display("output test done");
    endtask
    // Odd divide keeps equal high and low time; no bypass outside full
    task automatic test_div();
        cfg.mode = MODE_EXT_VCO;
        cfg.div_bypass = 1'b1;
        cfg.vco_div = 6'h03;
        step(2);
        chk(ana.third_pole_resistor, 3'h0);
        chk(ana.fourth_pole_cap, 3'h0);
        pulse_div();
        step(80);
        wait_rfc(1'b1, n);
        wait_rfc(1'b0, n);
        wait_rfc(1'b1, n);
        chk(n, 12);
        wait_rfc(1'b0, n);
        chk(n, 12);
        cfg.mode = MODE_FULL;
        cfg.div_bypass = 1'b0;
        $display("divider test done");
    endtask
    // Divide by 4 needs a rewrite after a trigger write in full chip
    task automatic test_resync();
        cfg.vco_div = 6'h04;
        pulse_div();
        step(60);
        chk(rsn, 1'b0);
        pulse_trig();
        chk(rsn, 1'b1);
        step(2);
        pulse_div();
        chk(rsn, 1'b0);
        $display("resync test done");
    endtask
    initial begin
        cfg = '0;
        cfg.mode = MODE_FULL;
        cfg.third_pole_resistor = 3'h5;
        cfg.fourth_pole_cap = 3'h6;
        cfg.reference_freq_word = 12'h010;
        cfg.n_int = 16'h9c40;
        cfg.pump_gain = 5'h03;
        cfg.fast_settle_pump_gain = 5'h1f;
        cfg.fast_third_pole_resistor = 3'h1;
        cfg.amplitude_cal_temp_comp = 1'b1;
        cfg.vco_div = 6'h02;
        cfg.output_state_word = 2'h1;
        cfg.fast_settle_time = 16'h000a;
        step(8);
        sys_rst = 1'b0;
        step(5);
        test_trig();
        test_power();
        test_out();
        test_div();
        test_resync();
        end_of_test();
    end
endmodule
